// ---- verilog/tgs_pkg.sv ----
// shared constants and types for the timer gate-source block
package tgs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_PIE    = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK   = 8'h10;
    localparam logic [7:0] OFS_COUNT  = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and encodings
    localparam int PIE_GATE_BIT = 7;
    localparam int PIE_OVF_BIT  = 0;
    localparam logic [1:0] GS_PIN = 2'h0;
    localparam logic [1:0] GS_T0  = 2'h1;
    localparam logic [1:0] GS_T2  = 2'h2;
    localparam logic [1:0] GS_WDT = 2'h3;
    localparam int ST_OVF  = 0;
    localparam int ST_GATE = 1;
    localparam int ST_T0   = 2;
    localparam int ST_T2   = 3;
    localparam int ST_WDT  = 4;
    localparam int ST_BITS = 5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  PIE_RST    = 8'h00;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [7:0]  PERIOD_RST = 8'hFF;
    localparam logic [4:0]  MASK_RST   = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control word, high bit first
    typedef struct packed {
        logic [3:0] spare;
        logic       timer0Run;
        logic       secondTimerRun;
        logic       peripheralIrqMasterEnable;
        logic       watchdogEnable;
        logic [2:0] prescalerRatio;
        logic       prescalerAssign;
        logic       timerOnControl;
        logic [1:0] gateSourceSelect;
        logic       timerGateEnable;
    } tgs_ctrl_t;

    // watchdog event inputs from the instruction decoder
    typedef struct packed {
        logic clearInstr;
        logic sleepInstr;
        logic wakeUp;
    } tgs_wdt_evt_t;

endpackage

// ---- verilog/tgs_second_timer.sv ----
// second 8-bit timer with period match reload and gate pulse
module tgs_second_timer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // control
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] period,
    // state
    output logic      [WIDTH-1:0] count,
    output logic                  matchPulse
);

    logic [WIDTH-1:0] count_q;
    logic             pulse_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_q <= '0;
        end else if (run) begin
            if (count_q == period) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + WIDTH'(1);
            end
        end
    end

    // one cycle wide, raised by the reload itself
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= run && (count_q == period);
        end
    end

    assign count      = count_q;
    assign matchPulse = pulse_q;

endmodule // tgs_second_timer

// ---- verilog/tgs_watchdog.sv ----
// watchdog prescaler and counter, ticked by its own oscillator
module tgs_watchdog #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // control
    input  wire logic                  oscEnable,
    input  wire logic                  resetEnable,
    input  wire logic                  oscTick,
    input  wire logic                  prescalerAssign,
    input  wire logic [2:0]            prescalerRatio,
    input  wire tgs_pkg::tgs_wdt_evt_t evt,
    // results
    output logic                       overflowPulse,
    output logic                       watchdogReset
);

    logic [7:0]       pre_q;
    logic [WIDTH-1:0] cnt_q;
    logic             ovf_q;
    logic             rst_q;
    logic             clearAll;
    logic             preDone;

    // any clearing event restarts the interval under measurement
    assign clearAll = evt.clearInstr || evt.sleepInstr || evt.wakeUp;
    // ratio only counts while the prescaler belongs to the watchdog
    assign preDone  = !prescalerAssign ||
                      (pre_q == 8'((9'h001 << prescalerRatio) - 9'h001));

    always_ff @(posedge core_clk) begin
        if (srst || clearAll || !oscEnable) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else if (oscTick) begin
            pre_q <= preDone ? 8'h00 : pre_q + 8'h01;
            if (preDone) begin
                cnt_q <= cnt_q + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ovf_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            ovf_q <= oscEnable && !clearAll && oscTick && preDone && (&cnt_q);
            // gate use powers the oscillator but never arms the reset
            rst_q <= resetEnable && oscEnable && !clearAll && oscTick
                     && preDone && (&cnt_q);
        end
    end

    assign overflowPulse = ovf_q;
    assign watchdogReset = rst_q;

endmodule // tgs_watchdog

// ---- verilog/tgs_gate_source.sv ----
// gate-source selection, 16-bit timer, interrupt enables and bus slave
module tgs_gate_source #(
    parameter int WDT_WIDTH = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // axi4-lite write address and data
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // pins
    input  wire logic                  externalGatePin,
    input  wire logic                  watchdogOscTick,
    // instruction decoder events
    input  wire tgs_pkg::tgs_wdt_evt_t wdtEvt,
    // outputs
    output logic                       gateLevel,
    output logic                       watchdogOscOn,
    output logic                       watchdogReset,
    output logic                       peripheralIrq,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]               pie_q;
    tgs_pkg::tgs_ctrl_t       ctrl_q;
    logic [7:0]               period_q;
    logic [tgs_pkg::ST_BITS-1:0] status_q;
    logic [tgs_pkg::ST_BITS-1:0] mask_q;
    logic [7:0]               t0Count_q;
    logic [15:0]              t1Count_q;
    logic [7:0]               t2Count;
    logic                     t0Pulse_q;
    logic                     t2Pulse;
    logic                     wdtPulse;
    logic [1:0]               pinSync_q;
    logic [1:0]               tickSync_q;
    logic                     tickPrev_q;
    logic                     gate_q;
    logic                     gatePrev_q;
    logic                     t1Wrap;
    logic                     gateDone;
    logic [tgs_pkg::ST_BITS-1:0] events;

    // byte-lane merge, used for every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pinSync_q  <= 2'h0;
            tickSync_q <= 2'h0;
            tickPrev_q <= 1'b0;
        end else begin
            pinSync_q  <= {pinSync_q[0], externalGatePin};
            tickSync_q <= {tickSync_q[0], watchdogOscTick};
            tickPrev_q <= tickSync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer0 and its wrap pulse

    always_ff @(posedge core_clk) begin
        if (srst) begin
            t0Count_q <= 8'h00;
            t0Pulse_q <= 1'b0;
        end else begin
            if (ctrl_q.timer0Run) begin
                t0Count_q <= t0Count_q + 8'h01;
            end
            t0Pulse_q <= ctrl_q.timer0Run && (t0Count_q == 8'hFF);
        end
    end

    tgs_second_timer #(
        .WIDTH      (8)
    ) u_second_timer (
        .core_clk   (core_clk),
        .srst       (srst),
        .run        (ctrl_q.secondTimerRun),
        .period     (period_q),
        .count      (t2Count),
        .matchPulse (t2Pulse)
    );

    // power decision deliberately leaves the timer on bit out
    assign watchdogOscOn = ctrl_q.watchdogEnable ||
                           (ctrl_q.timerGateEnable &&
                            ctrl_q.gateSourceSelect == tgs_pkg::GS_WDT);

    tgs_watchdog #(
        .WIDTH           (WDT_WIDTH)
    ) u_watchdog (
        .core_clk        (core_clk),
        .srst            (srst),
        .oscEnable       (watchdogOscOn),
        .resetEnable     (ctrl_q.watchdogEnable),
        .oscTick         (tickSync_q[1] && !tickPrev_q),
        .prescalerAssign (ctrl_q.prescalerAssign),
        .prescalerRatio  (ctrl_q.prescalerRatio),
        .evt             (wdtEvt),
        .overflowPulse   (wdtPulse),
        .watchdogReset   (watchdogReset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // gate source mux and 16-bit timer

    always_ff @(posedge core_clk) begin
        if (srst) begin
            gate_q     <= 1'b0;
            gatePrev_q <= 1'b0;
        end else begin
            unique case (ctrl_q.gateSourceSelect)
                tgs_pkg::GS_PIN: gate_q <= pinSync_q[1];
                tgs_pkg::GS_T0:  gate_q <= t0Pulse_q;
                tgs_pkg::GS_T2:  gate_q <= t2Pulse;
                tgs_pkg::GS_WDT: gate_q <= wdtPulse;
            endcase
            gatePrev_q <= gate_q;
        end
    end

    assign gateLevel = gate_q;
    // acquisition ends when an enabled gate falls
    assign gateDone  = ctrl_q.timerOnControl && ctrl_q.timerGateEnable
                       && gatePrev_q && !gate_q;
    assign t1Wrap    = ctrl_q.timerOnControl && (!ctrl_q.timerGateEnable || gate_q)
                       && (t1Count_q == 16'hFFFF);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            t1Count_q <= 16'h0000;
        end else if (ctrl_q.timerOnControl && (!ctrl_q.timerGateEnable || gate_q)) begin
            t1Count_q <= t1Count_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic       awHeld_q;
    logic       wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic       doWrite;
    logic       doRead;
    logic       readStatus;
    logic [31:0] rdMux;
    logic       rdHit;

    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeld_q && wHeld_q;
    assign doRead        = s_axi_arvalid && s_axi_arready;
    assign readStatus    = doRead && (s_axi_araddr == tgs_pkg::OFS_STATUS);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tgs_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            unique case (awAddr_q)
                tgs_pkg::OFS_PIE, tgs_pkg::OFS_CTRL, tgs_pkg::OFS_PERIOD,
                tgs_pkg::OFS_MASK: s_axi_bresp <= tgs_pkg::RESP_OKAY;
                default:           s_axi_bresp <= tgs_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pie_q    <= tgs_pkg::PIE_RST;
            ctrl_q   <= tgs_pkg::CTRL_RST;
            period_q <= tgs_pkg::PERIOD_RST;
            mask_q   <= tgs_pkg::MASK_RST;
        end else if (doWrite) begin
            unique case (awAddr_q)
                tgs_pkg::OFS_PIE:    pie_q    <= 8'(merge({24'h0, pie_q}, wData_q, wStrb_q));
                tgs_pkg::OFS_CTRL:   ctrl_q   <= 16'(merge({16'h0, ctrl_q}, wData_q, wStrb_q));
                tgs_pkg::OFS_PERIOD: period_q <= 8'(merge({24'h0, period_q}, wData_q, wStrb_q));
                tgs_pkg::OFS_MASK:   mask_q   <= 5'(merge({27'h0, mask_q}, wData_q, wStrb_q));
                default: ;
            endcase
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            tgs_pkg::OFS_PIE:    rdMux = {24'h0, pie_q};
            tgs_pkg::OFS_CTRL:   rdMux = {16'h0, ctrl_q};
            tgs_pkg::OFS_PERIOD: rdMux = {24'h0, period_q};
            tgs_pkg::OFS_STATUS: rdMux = {27'h0, status_q};
            tgs_pkg::OFS_MASK:   rdMux = {27'h0, mask_q};
            tgs_pkg::OFS_COUNT:  rdMux = {t2Count, t0Count_q, t1Count_q};
            default:             rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= tgs_pkg::RESP_OKAY;
        end else if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdHit ? tgs_pkg::RESP_OKAY : tgs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, read clears, a new event wins over the clear

    assign events = {wdtPulse, t2Pulse, t0Pulse_q, gateDone, t1Wrap};

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_q <= '0;
        end else if (readStatus) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq           <= 1'b0;
            peripheralIrq <= 1'b0;
        end else begin
            irq           <= |(status_q & mask_q);
            peripheralIrq <= ctrl_q.peripheralIrqMasterEnable &&
                             ((pie_q[tgs_pkg::PIE_GATE_BIT] && status_q[tgs_pkg::ST_GATE]) ||
                              (pie_q[tgs_pkg::PIE_OVF_BIT] && status_q[tgs_pkg::ST_OVF]));
        end
    end

endmodule // tgs_gate_source

// ---- sim/tgs_gate_source_asserts.sv ----
// concurrent checks on the gate-source block ports
module tgs_gate_source_asserts #(
    parameter int WDT_WIDTH = 8
) (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // bus handshakes
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    // events and outputs
    input wire tgs_pkg::tgs_wdt_evt_t wdtEvt,
    input wire logic                  gateLevel,
    input wire logic                  watchdogOscOn,
    input wire logic                  watchdogReset,
    input wire logic                  peripheralIrq,
    input wire logic                  irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not offered one cycle after address");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data offered twice");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response offered twice");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_wdt_quiet: assert property (!watchdogOscOn [*3] |-> !watchdogReset)
        else $error("watchdog reset with oscillator off");
    chk_wdt_restart: assert property (wdtEvt != '0 |-> ##2 !watchdogReset [*3])
        else $error("watchdog fired right after restart");
    chk_reset_quiet: assert property ($fell(srst) |-> !irq && !peripheralIrq && !gateLevel)
        else $error("outputs active after reset");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(peripheralIrq));
    cover property ($rose(gateLevel) ##1 !gateLevel);
endmodule // tgs_gate_source_asserts

bind tgs_gate_source tgs_gate_source_asserts #(.WDT_WIDTH(WDT_WIDTH)) u_asserts (
    .core_clk(core_clk), .srst(srst),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wdtEvt(wdtEvt), .gateLevel(gateLevel), .watchdogOscOn(watchdogOscOn),
    .watchdogReset(watchdogReset), .peripheralIrq(peripheralIrq), .irq(irq)
);

// ---- sim/tgs_far_side.sv ----
// far-side model: watchdog oscillator ticks and decoder restart events
module tgs_far_side (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // controls
    input  wire logic             oscOn,
    input  wire logic             restartOn,
    // outputs
    output logic                  oscTick,
    output tgs_pkg::tgs_wdt_evt_t evt
);
    logic [2:0] divQ;
    logic [4:0] gapQ;
    logic [1:0] kindQ;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator stands still while unpowered, rising every 8 cycles when on
    always_ff @(posedge core_clk) begin
        divQ    <= (oscOn && !srst) ? divQ + 3'h1 : 3'h0;
        oscTick <= oscOn & divQ[2] & !srst;
    end

    // wake, sleep and clear in turn, well inside one time-out
    always_ff @(posedge core_clk) begin
        gapQ <= (restartOn && gapQ != 5'h17) ? gapQ + 5'h1 : 5'h0;
        evt  <= '0;
        if (srst) begin
            kindQ <= 2'h0;
        end else if (restartOn && gapQ == 5'h17) begin
            kindQ <= (kindQ == 2'h2) ? 2'h0 : kindQ + 2'h1;
            evt   <= tgs_pkg::tgs_wdt_evt_t'(3'h1 << kindQ);
        end
    end
endmodule // tgs_far_side

// ---- sim/tb.sv ----
// self-checking bench for the timer gate-source block
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [7:0]  awAddr   = 8'h00;
    logic [7:0]  arAddr   = 8'h00;
    logic [31:0] wData    = 32'h0;
    logic        awValid  = 1'b0;
    logic        wValid   = 1'b0;
    logic        bReady   = 1'b0;
    logic        arValid  = 1'b0;
    logic        rReady   = 1'b0;
    logic        gatePin  = 1'b0;
    logic        restartOn = 1'b0;
    logic        resetSeen = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid, oscTick, oscOn;
    logic        gateLevel, wdtReset, perIrq, irq, seen, wide;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    tgs_pkg::tgs_wdt_evt_t wdtEvt;
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    int          per;

    always #5 core_clk = ~core_clk;

    tgs_gate_source #(.WDT_WIDTH(3)) u_dut (
        .core_clk(core_clk), .srst(srst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .externalGatePin(gatePin), .watchdogOscTick(oscTick), .wdtEvt(wdtEvt),
        .gateLevel(gateLevel), .watchdogOscOn(oscOn), .watchdogReset(wdtReset),
        .peripheralIrq(perIrq), .irq(irq)
    );

    tgs_far_side u_far (
        .core_clk(core_clk), .srst(srst), .oscOn(oscOn), .restartOn(restartOn),
        .oscTick(oscTick), .evt(wdtEvt)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (wdtReset === 1'b1) resetSeen <= 1'b1;
        if (cycles == 90000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seenV, input logic [31:0] expV);
        checked++;
        if (seenV !== expV) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, seenV, expV);
        end
    endtask

    task automatic writeCheck(input logic [7:0] a, input logic [31:0] d,
                              input logic [1:0] r = tgs_pkg::RESP_OKAY);
        logic awT, wT, bT;
        logic [1:0] rs;
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        bT = 1'b0;
        while (!bT) begin
            @(negedge core_clk);
            awT = awValid & awReady;
            wT = wValid & wReady;
            bT = bValid === 1'b1;
            rs = bResp;
            @(posedge core_clk);
            if (awT) awValid <= 1'b0;
            if (wT) wValid <= 1'b0;
        end
        bReady <= 1'b0;
        check(32'(rs), 32'(r));
    endtask

    task automatic readCheck(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] r = tgs_pkg::RESP_OKAY);
        logic arT, rT;
        logic [1:0] rs;
        logic [31:0] ds;
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        rT = 1'b0;
        while (!rT) begin
            @(negedge core_clk);
            arT = arValid & arReady;
            rT = rValid === 1'b1;
            rs = rResp;
            ds = rData;
            @(posedge core_clk);
            if (arT) arValid <= 1'b0;
        end
        rReady <= 1'b0;
        check(ds, d);
        check(32'(rs), 32'(r));
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // pin passes two sync stages and the registered mux
    task automatic pinTo(input logic v);
        @(posedge core_clk);
        gatePin <= v;
        settle(5);
    endtask

    task automatic waitHigh(input logic usePer, input int lim, output logic hit);
        int n;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(negedge core_clk);
            hit = (usePer ? perIrq : irq) === 1'b1;
            n++;
        end
    endtask

    // spacing of internal gate pulses and width of one
    task automatic gatePulses(output int p, output logic w);
        int n;
        n = 0;
        @(negedge core_clk);
        while (gateLevel !== 1'b1 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        w = gateLevel;
        p = 1;
        while (gateLevel !== 1'b1 && p < 600) begin
            @(negedge core_clk);
            p++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        readCheck(tgs_pkg::OFS_PIE, 32'h0);
        writeCheck(tgs_pkg::OFS_PIE, 32'hFFFFFFFF);
        readCheck(tgs_pkg::OFS_PIE, 32'hFF);
        readCheck(8'h18, 32'h0, tgs_pkg::RESP_SLVERR);
        writeCheck(tgs_pkg::OFS_COUNT, 32'h0, tgs_pkg::RESP_SLVERR);
        pinTo(1'b1);
        check(32'(gateLevel), 32'h1);
        pinTo(1'b0);
        check(32'(gateLevel), 32'h0);
        writeCheck(tgs_pkg::OFS_PIE, 32'h80);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0009);
        pinTo(1'b1);
        pinTo(1'b0);
        check(32'(perIrq), 32'h0);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0209);
        settle(3);
        check(32'(perIrq), 32'h1);
        writeCheck(tgs_pkg::OFS_PIE, 32'h0);
        settle(3);
        check(32'(perIrq), 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h2);
        writeCheck(tgs_pkg::OFS_MASK, 32'h14);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0802);
        gatePulses(per, wide);
        check(32'(per), 32'h100);
        check(32'(wide), 32'h0);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0);
        settle(1);
        check(32'(irq), 32'h1);
        readCheck(tgs_pkg::OFS_STATUS, 32'h4);
        settle(3);
        check(32'(irq), 32'h0);
        writeCheck(tgs_pkg::OFS_PERIOD, 32'h5);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0404);
        gatePulses(per, wide);
        check(32'(per), 32'h6);
        check(32'(wide), 32'h0);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h8);
        // toggle handling lies outside this block
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0007);
        settle(1);
        check(32'(oscOn), 32'h1);
        waitHigh(1'b0, 600, seen);
        check(32'(seen), 32'h1);
        check(32'(resetSeen), 32'h0);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0);
        settle(1);
        check(32'(oscOn), 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h10);
        restartOn <= 1'b1;
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0007);
        settle(300);
        @(posedge core_clk);
        restartOn <= 1'b0;
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h0);
        // prescaler set in the same write that starts the oscillator
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0037);
        settle(90);
        check(32'(irq), 32'h0);
        waitHigh(1'b0, 400, seen);
        check(32'(seen), 32'h1);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h10);
        writeCheck(tgs_pkg::OFS_PIE, 32'h1);
        writeCheck(tgs_pkg::OFS_CTRL, 32'h0208);
        waitHigh(1'b1, 70000, seen);
        check(32'(seen), 32'h1);
        writeCheck(tgs_pkg::OFS_PIE, 32'h0);
        settle(3);
        check(32'(perIrq), 32'h0);
        readCheck(tgs_pkg::OFS_STATUS, 32'h1);
        end_of_test();
    end
endmodule // tb
